// ===== cspt_defines.vh
// constants of the serial configuration port: instruction layout,
// local register addresses, field positions and reset values.
// included by every file of the port except the synchroniser and host model; holds definitions only.
`ifndef CSPT_DEFINES_VH
`define CSPT_DEFINES_VH

// ****************************************************************
// instruction word
// ****************************************************************
`define CSPT_INSTR_BITS 16
`define CSPT_INSTR_LAST 4'hf
`define CSPT_RW_BIT 15
`define CSPT_LEN_HI_BIT 14
`define CSPT_LEN_LO_BIT 13
`define CSPT_ADDR_W 13
`define CSPT_LEN_STREAM 2'h3
`define CSPT_BYTE_LAST 4'h7

// ****************************************************************
// local registers
// ****************************************************************
`define CSPT_ADDR_CFG 13'h0000
`define CSPT_ADDR_XFER 13'h00ff
`define CSPT_XFER_GO 8'h01
`define CSPT_XFER_READ 8'h00
`define CSPT_CFG_LSB_BIT 6
`define CSPT_CFG_RESET 8'h00

// ****************************************************************
// shadowed register set
// ****************************************************************
`define CSPT_SHADOW_N 26
`define CSPT_SHADOW_RESET 8'h00
`define CSPT_SH_BLOCK_LO 13'h003a
`define CSPT_SH_BLOCK_HI 13'h004c
`define CSPT_SH_BLOCK_BASE 5'h07

`endif

// ===== cspt_sync.v
// two flip-flop synchronisers for the pins of the serial port.
// assumes the pins are asynchronous to clk_sys.
`timescale 1ns/1ps

module cspt_sync #(
    parameter WIDTH = 3
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [WIDTH-1:0] async_in,
    input wire [WIDTH-1:0] reset_val,
    output wire [WIDTH-1:0] sync_out
);

// ****************************************************************
// one synchroniser per pin
// ****************************************************************
genvar gi;
generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
        reg meta_r;
        reg hold_r;
        // first stage only feeds the second; reset level is the idle one
        always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                meta_r <= 1'b1;
                hold_r <= 1'b1;
            end else begin
                meta_r <= async_in[gi];
                hold_r <= meta_r;
            end
        end
        assign sync_out[gi] = hold_r & reset_val[gi] |
                              hold_r & ~reset_val[gi];
    end
endgenerate

endmodule // cspt_sync

// ===== cspt_shadow.v
// staged and active copies of the shadowed configuration registers.
// assumes write and apply strobes are one-cycle pulses on clk_sys.
`timescale 1ns/1ps
`include "cspt_defines.vh"

module cspt_shadow (
    input wire clk_sys,
    input wire rst_n,
    input wire [`CSPT_ADDR_W-1:0] addr,
    input wire wr,
    input wire [7:0] wdata,
    input wire apply,
    output wire hit,
    output wire [7:0] staged_rdata,
    output wire [`CSPT_SHADOW_N*8-1:0] active
);

// ****************************************************************
// address decode
// ****************************************************************
function [5:0] cspt_sh_index;
    input [`CSPT_ADDR_W-1:0] a;
    reg [`CSPT_ADDR_W-1:0] off;
    begin
        off = a - `CSPT_SH_BLOCK_LO +
              {{(`CSPT_ADDR_W-5){1'b0}}, `CSPT_SH_BLOCK_BASE};
        cspt_sh_index = 6'h00;
        case (a)
            13'h0009: cspt_sh_index = 6'h20;
            13'h000b: cspt_sh_index = 6'h21;
            13'h000d: cspt_sh_index = 6'h22;
            13'h0010: cspt_sh_index = 6'h23;
            13'h0014: cspt_sh_index = 6'h24;
            13'h0018: cspt_sh_index = 6'h25;
            13'h0021: cspt_sh_index = 6'h26;
            default: begin
                if (a >= `CSPT_SH_BLOCK_LO && a <= `CSPT_SH_BLOCK_HI) begin
                    cspt_sh_index = {1'b1, off[4:0]};
                end
            end
        endcase
    end
endfunction

wire [5:0] idx_w;
assign idx_w = cspt_sh_index(addr);
assign hit = idx_w[5];

reg [7:0] staged_r [0:`CSPT_SHADOW_N-1];
reg [7:0] active_r [0:`CSPT_SHADOW_N-1];

assign staged_rdata = hit ? staged_r[idx_w[4:0]] : 8'h00;

// ****************************************************************
// storage: writes stage, the transfer command copies all at once
// ****************************************************************
genvar gi;
generate
    for (gi = 0; gi < `CSPT_SHADOW_N; gi = gi + 1) begin : g_reg
        always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                staged_r[gi] <= `CSPT_SHADOW_RESET;
                active_r[gi] <= `CSPT_SHADOW_RESET;
            end else begin
                if (wr && hit && idx_w[4:0] == gi) begin
                    staged_r[gi] <= wdata;
                end
                if (apply) begin
                    active_r[gi] <= staged_r[gi];
                end
            end
        end
        assign active[gi*8 +: 8] = active_r[gi];
    end
endgenerate

endmodule // cspt_shadow

// ===== cspt_port.v
// serial configuration port: three-wire slave with byte register space.
// assumes sclk, cs_n and sdio_i are asynchronous pins, sclk at least
// eight clk_sys periods long; the chip register file answers reg_rdata
// in the cycle after reg_rd.
//
// Summary of operation
// - a frame starts at the first sclk rise after cs_n has gone low.
// - every frame opens with a 16-bit instruction word.
// - the two length bits of the instruction give the byte count.
// - data moves in 8-bit words and addresses select single bytes.
// - the read/write bit of the instruction decides the turnaround.
// - on a read the data pin turns to output and sends register data.
// - with cs_n held low the port takes a new instruction after each counted transfer; a stream runs on.
// - cs_n raised between bytes stalls a counted transfer, which resumes; a stream ends.
// - with cs_n high the pins float; secondary use is enabled unless a transfer is stalled.
// - bits go msb first after reset, lsb first when configured.
// - sclk and cs_n are inputs; sdio drives only while reading.
// - nothing is transferred while cs_n is high.
// - all shifting runs on the sample clock, at detected host clock edges.
// - shadowed writes act only after 0x01 goes to the transfer byte.
`timescale 1ns/1ps
`include "cspt_defines.vh"

module cspt_port (
    input wire clk_sys,
    input wire rst_n,
    input wire sclk,
    input wire cs_n,
    input wire sdio_i,
    output wire sdio_o,
    output wire sdio_oe_n,
    output wire pins_secondary,
    output wire lsb_first,
    output wire [`CSPT_ADDR_W-1:0] reg_addr,
    output wire [7:0] reg_wdata,
    output wire reg_wr,
    output wire reg_rd,
    input wire [7:0] reg_rdata,
    output wire xfer_apply,
    output wire [`CSPT_SHADOW_N*8-1:0] shadow_active
);

// ****************************************************************
// pin synchronisers and host clock edges
// ****************************************************************
wire [2:0] pins_s;
wire sclk_s;
wire cs_n_s;
wire sdio_s;
reg sclk_d_r;

cspt_sync #(.WIDTH(3)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({sdio_i, cs_n, sclk}),
    .reset_val(3'h7),
    .sync_out(pins_s)
);

assign sclk_s = pins_s[0];
assign cs_n_s = pins_s[1];
assign sdio_s = pins_s[2];

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        sclk_d_r <= 1'b1;
    end else begin
        sclk_d_r <= sclk_s;
    end
end

// edges of the host clock only count while selected
wire sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
wire sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;

// ****************************************************************
// state and registers
// ****************************************************************
localparam ST_IDLE = 4'h1;
localparam ST_INSTR = 4'h2;
localparam ST_DATA = 4'h4;
localparam ST_STALL = 4'h8;

reg [3:0] state_r;
reg [3:0] state_nxt;
reg [15:0] instr_r;
reg [3:0] bit_cnt_r;
reg rw_r;
reg stream_r;
reg [1:0] left_r;
reg [`CSPT_ADDR_W-1:0] addr_r;
reg [7:0] rx_r;
reg [7:0] tx_r;
reg [7:0] cfg_r;
reg load_r;
reg wr_r;
reg [7:0] wdata_r;
reg rd_r;
reg apply_r;
reg secondary_r;
reg step_r;

wire lsb_w = cfg_r[`CSPT_CFG_LSB_BIT];
wire byte_end = (bit_cnt_r == `CSPT_BYTE_LAST);
wire last_byte = (left_r == 2'h0) & ~stream_r;
wire [`CSPT_ADDR_W-1:0] addr_inc = addr_r +
                                   {{(`CSPT_ADDR_W-1){1'b0}}, 1'b1};

// ****************************************************************
// local address decode, shared by read and write paths
// ****************************************************************
function cspt_is_cfg;
    input [`CSPT_ADDR_W-1:0] a;
    begin
        cspt_is_cfg = (a == `CSPT_ADDR_CFG);
    end
endfunction

function cspt_is_xfer;
    input [`CSPT_ADDR_W-1:0] a;
    begin
        cspt_is_xfer = (a == `CSPT_ADDR_XFER);
    end
endfunction

wire sh_hit;
wire [7:0] sh_rdata;
wire local_hit = cspt_is_cfg(addr_r) | cspt_is_xfer(addr_r) | sh_hit;

// shift-in of one bit, direction set by the bit order
wire [15:0] instr_shift = lsb_w ? {sdio_s, instr_r[15:1]} :
                                  {instr_r[14:0], sdio_s};
wire [7:0] rx_shift = lsb_w ? {sdio_s, rx_r[7:1]} :
                              {rx_r[6:0], sdio_s};

// ****************************************************************
// frame sequencer
// ****************************************************************
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE: begin
            if (!cs_n_s) begin
                state_nxt = ST_INSTR;
            end
        end
        ST_INSTR: begin
            if (cs_n_s) begin
                state_nxt = ST_IDLE;
            end else if (sclk_rise && bit_cnt_r == `CSPT_INSTR_LAST) begin
                state_nxt = ST_DATA;
            end
        end
        ST_DATA: begin
            if (cs_n_s) begin
                // a clean byte boundary with bytes still owed is a stall
                if (bit_cnt_r == 4'h0 && !stream_r) begin
                    state_nxt = ST_STALL;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end else if (sclk_rise && byte_end && last_byte) begin
                state_nxt = ST_INSTR;
            end
        end
        ST_STALL: begin
            if (!cs_n_s) begin
                state_nxt = ST_DATA;
            end
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= ST_IDLE;
        instr_r <= 16'h0000;
        bit_cnt_r <= 4'h0;
        rw_r <= 1'b0;
        stream_r <= 1'b0;
        left_r <= 2'h0;
        addr_r <= {`CSPT_ADDR_W{1'b0}};
        rx_r <= 8'h00;
        load_r <= 1'b0;
        rd_r <= 1'b0;
        step_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        load_r <= rd_r;
        rd_r <= 1'b0;
        step_r <= 1'b0;
        if (step_r) begin
            addr_r <= addr_inc;
        end
        if (state_nxt == ST_IDLE) begin
            bit_cnt_r <= 4'h0;
        end
        if (sclk_rise && state_r == ST_INSTR) begin
            instr_r <= instr_shift;
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == `CSPT_INSTR_LAST) begin
                bit_cnt_r <= 4'h0;
                rw_r <= instr_shift[`CSPT_RW_BIT];
                left_r <= {instr_shift[`CSPT_LEN_HI_BIT],
                           instr_shift[`CSPT_LEN_LO_BIT]};
                stream_r <= ({instr_shift[`CSPT_LEN_HI_BIT],
                              instr_shift[`CSPT_LEN_LO_BIT]} ==
                             `CSPT_LEN_STREAM);
                addr_r <= instr_shift[`CSPT_ADDR_W-1:0];
                rd_r <= instr_shift[`CSPT_RW_BIT];
            end
        end
        if (sclk_rise && state_r == ST_DATA) begin
            rx_r <= rx_shift;
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (byte_end) begin
                bit_cnt_r <= 4'h0;
                // a write keeps its address until its strobe has gone out
                if (rw_r) begin
                    addr_r <= addr_inc;
                end else begin
                    step_r <= 1'b1;
                end
                if (!stream_r && left_r != 2'h0) begin
                    left_r <= left_r - 2'h1;
                end
                rd_r <= rw_r & ~last_byte;
            end
        end
    end
end

// ****************************************************************
// write path: local registers, shadow set or chip register file
// ****************************************************************
wire byte_done_wr = sclk_rise & (state_r == ST_DATA) & byte_end & ~rw_r;

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        cfg_r <= `CSPT_CFG_RESET;
        wr_r <= 1'b0;
        wdata_r <= 8'h00;
        apply_r <= 1'b0;
    end else begin
        wr_r <= 1'b0;
        apply_r <= 1'b0;
        if (byte_done_wr) begin
            wdata_r <= rx_shift;
            if (cspt_is_cfg(addr_r)) begin
                cfg_r <= rx_shift;
            end else if (cspt_is_xfer(addr_r)) begin
                // transfer byte reads back zero: it clears itself
                apply_r <= (rx_shift == `CSPT_XFER_GO);
            end else if (!sh_hit) begin
                wr_r <= 1'b1;
            end
        end
    end
end

cspt_shadow u_shadow (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .addr(addr_r),
    .wr(byte_done_wr),
    .wdata(rx_shift),
    .apply(apply_r),
    .hit(sh_hit),
    .staged_rdata(sh_rdata),
    .active(shadow_active)
);

// ****************************************************************
// read path: byte loaded after the address settles, shifted on falls
// ****************************************************************
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        tx_r <= 8'h00;
    end else if (load_r) begin
        if (cspt_is_cfg(addr_r)) begin
            tx_r <= cfg_r;
        end else if (cspt_is_xfer(addr_r)) begin
            tx_r <= `CSPT_XFER_READ;
        end else if (sh_hit) begin
            tx_r <= sh_rdata;
        end else begin
            tx_r <= reg_rdata;
        end
    end else if (sclk_fall && state_r == ST_DATA && rw_r &&
                 bit_cnt_r != 4'h0) begin
        tx_r <= lsb_w ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
    end
end

// ****************************************************************
// pin drive and secondary-function status
// ****************************************************************
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        secondary_r <= 1'b1;
    end else begin
        secondary_r <= cs_n_s & (state_nxt == ST_IDLE);
    end
end

// only a read data phase with cs_n low drives the pin
assign sdio_oe_n = ~((state_r == ST_DATA) & rw_r & ~cs_n_s);
assign sdio_o = lsb_w ? tx_r[0] : tx_r[7];
assign pins_secondary = secondary_r;
assign lsb_first = lsb_w;
assign reg_addr = addr_r;
assign reg_wdata = wdata_r;
assign reg_wr = wr_r;
assign reg_rd = rd_r & ~local_hit;
assign xfer_apply = apply_r;

endmodule // cspt_port

// ===== cspt_port_sva.sv
// checker for the serial configuration port, bound to cspt_port.
// assumes clk_sys at 100 MHz and rst_n active low.
`timescale 1ns/1ps
`include "cspt_defines.vh"

module cspt_port_sva (
    input wire clk_sys,
    input wire rst_n,
    input wire cs_n,
    input wire sdio_oe_n,
    input wire pins_secondary,
    input wire reg_wr,
    input wire reg_rd,
    input wire xfer_apply,
    input wire [`CSPT_SHADOW_N*8-1:0] shadow_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // port behaviour
    // ****************************************
    // a byte takes at least 128 cycles, so two strobes can never be close
    a_wr_byte_spacing: assert property (reg_wr |=> !reg_wr [*8])
        else $error("register write strobe repeated inside one byte");
    a_rd_byte_spacing: assert property (reg_rd |=> !reg_rd [*8])
        else $error("register read strobe repeated inside one byte");
    a_apply_one_pulse: assert property ($rose(xfer_apply) |=> !xfer_apply [*8])
        else $error("apply strobe longer than one cycle");
    // covers both a same-edge and a next-edge update of the active copy
    a_shadow_held: assert property (!xfer_apply [*3] |-> $stable(shadow_active))
        else $error("active shadow copy changed without apply");
    a_idle_pins_float: assert property (pins_secondary |-> sdio_oe_n)
        else $error("data pin driven while port idle");
    a_cs_high_quiet: assert property (cs_n [*8] |-> sdio_oe_n && !reg_wr && !reg_rd)
        else $error("activity while chip select high");
    a_write_no_drive: assert property (reg_wr |-> sdio_oe_n)
        else $error("data pin driven during a write");
    a_read_turns_pin: assert property (reg_rd |-> ##[0:3] !sdio_oe_n)
        else $error("data pin not turned around on read");
endmodule // cspt_port_sva

bind cspt_port cspt_port_sva u_sva (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sdio_oe_n(sdio_oe_n),
    .pins_secondary(pins_secondary),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .xfer_apply(xfer_apply),
    .shadow_active(shadow_active)
);

// ===== cspt_host.sv
// behavioural host master of the three-wire port.
// assumes the bench resolves the data wire from both drivers.
`timescale 1ns/1ps

module cspt_host (
    input wire logic clk_sys,
    input wire logic sdio_line,
    output logic sclk,
    output logic cs_n,
    output logic host_d,
    output logic host_en
);
    logic lsb = 1'b0;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        host_d = 1'b0;
        host_en = 1'b1;
    end
    task wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // the link clock stands still outside bytes to keep the sampler quiet
    task sel(input logic v);
        wait_clk(8);
        cs_n = v;
        wait_clk(8);
    endtask
    // 160 ns link period, data changes on the fall, sampled on the rise
    task byte8(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
        int i;
        int k;
        for (i = 0; i < 8; i++) begin
            k = lsb ? i : 7 - i;
            wait_clk(8);
            sclk = 1'b0;
            host_en = drv;
            if (drv) host_d = tx[k];
            wait_clk(8);
            sclk = 1'b1;
            rx[k] = sdio_line;
        end
    endtask
    task ins(input logic [15:0] w);
        logic [7:0] r;
        if (lsb) begin
            byte8(w[7:0], 1'b1, r);
            byte8(w[15:8], 1'b1, r);
        end else begin
            byte8(w[15:8], 1'b1, r);
            byte8(w[7:0], 1'b1, r);
        end
    endtask
endmodule // cspt_host

// ===== cspt_tb.sv
// self-checking bench of cspt_port driven by the cspt_host model.
// assumes the design files and cspt_port_sva.sv are compiled first.
`timescale 1ns/1ps
`include "cspt_defines.vh"

module testbench;
    logic clk_sys = 1'b0;
    logic rst_n;
    wire sdio_o, sdio_oe_n, pins_secondary, lsb_first;
    wire reg_wr, reg_rd, xfer_apply;
    wire [12:0] reg_addr;
    logic [12:0] last_a;
    wire [7:0] reg_wdata;
    logic [7:0] last_d;
    logic [7:0] reg_rdata;
    wire [`CSPT_SHADOW_N*8-1:0] shadow_active;
    logic [7:0] tx [4];
    logic [7:0] rx [4];
    wire sclk, cs_n, host_d, host_en, sdio_line;
    int failures = 0;
    int compares = 0;
    int wr_n = 0;
    int ap_n = 0;

    always #5 clk_sys = ~clk_sys;
    // released by the host and not driven: inverse of the last value
    assign sdio_line = !sdio_oe_n ? sdio_o : host_en ? host_d : ~host_d;

    cspt_port DUT (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
        .cs_n(cs_n), .sdio_i(sdio_line), .sdio_o(sdio_o),
        .sdio_oe_n(sdio_oe_n), .pins_secondary(pins_secondary),
        .lsb_first(lsb_first), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .xfer_apply(xfer_apply), .shadow_active(shadow_active));
    cspt_host host (.clk_sys(clk_sys), .sdio_line(sdio_line), .sclk(sclk),
        .cs_n(cs_n), .host_d(host_d), .host_en(host_en));

    // chip register file: answers one cycle after the read strobe
    always @(posedge clk_sys) begin
        if (!rst_n) reg_rdata <= 8'h00;
        else if (reg_rd) reg_rdata <= reg_addr[7:0] ^ 8'h5a;
        if (reg_wr) begin
            wr_n <= wr_n + 1;
            last_a <= reg_addr;
            last_d <= reg_wdata;
        end
        if (xfer_apply) ap_n <= ap_n + 1;
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task frame(input logic rw, input logic [1:0] len, input logic [12:0] a,
               input int n);
        int i;
        host.ins({rw, len, a});
        for (i = 0; i < n; i++) host.byte8(tx[i], !rw, rx[i]);
    endtask
    task wr1(input logic [12:0] a, input logic [7:0] d);
        tx[0] = d;
        host.sel(1'b0);
        frame(1'b0, 2'h0, a, 1);
        host.sel(1'b1);
    endtask
    task rd1(input logic [12:0] a);
        host.sel(1'b0);
        frame(1'b1, 2'h0, a, 1);
        host.sel(1'b1);
    endtask

    // ****************************************
    // watchdog and main sequence
    // ****************************************
    // the tests need about 9k cycles; allow over five times that
    initial begin
        #500000;
        failures++;
        final_report;
    end

    initial begin
        int L, n, w0;
        rst_n = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(16'(pins_secondary), 16'h0001);
        chk(16'(sdio_oe_n), 16'h0001);
        chk(16'(lsb_first), 16'h0000);
        chk(16'(shadow_active[15:0]), 16'h0000);
        host.byte8(8'h00, 1'b1, rx[0]);
        host.byte8(8'h30, 1'b1, rx[0]);
        host.byte8(8'hff, 1'b1, rx[0]);
        chk(16'(wr_n), 16'h0000);
        wr1(13'h0030, 8'ha5);
        chk(16'(last_a), 16'h0030);
        chk(16'(last_d), 16'h00a5);
        tx = '{8'h11, 8'h22, 8'h33, 8'h44};
        for (L = 0; L < 4; L++) begin
            n = (L == 3) ? 4 : L + 1;
            w0 = wr_n;
            host.sel(1'b0);
            chk(16'(pins_secondary), 16'h0000);
            frame(1'b0, L[1:0], 13'h0050 + 13'(L * 8), n);
            host.sel(1'b1);
            chk(16'(wr_n - w0), 16'(n));
            chk(16'(last_a), 16'h0050 + 16'(L * 8 + n - 1));
            chk(16'(last_d), 16'(tx[n-1]));
        end
        host.sel(1'b0);
        frame(1'b1, 2'h1, 13'h0060, 2);
        host.sel(1'b1);
        chk(16'(rx[0]), 16'h003a);
        chk(16'(rx[1]), 16'h003b);
        w0 = wr_n;
        tx[0] = 8'h12;
        host.sel(1'b0);
        frame(1'b0, 2'h0, 13'h0070, 1);
        tx[0] = 8'h34;
        frame(1'b0, 2'h0, 13'h0071, 1);
        host.sel(1'b1);
        chk(16'(wr_n - w0), 16'h0002);
        chk(16'(last_d), 16'h0034);
        host.sel(1'b0);
        host.ins({1'b0, 2'h1, 13'h0078});
        host.byte8(8'h5e, 1'b1, rx[0]);
        host.sel(1'b1);
        host.sel(1'b0);
        host.byte8(8'h6f, 1'b1, rx[0]);
        host.sel(1'b1);
        chk(16'(last_a), 16'h0079);
        chk(16'(last_d), 16'h006f);
        w0 = wr_n;
        wr1(13'h0009, 8'h3c);
        chk(16'(shadow_active[7:0]), 16'h0000);
        chk(16'(wr_n - w0), 16'h0000);
        rd1(13'h0009);
        chk(16'(rx[0]), 16'h003c);
        wr1(13'h0040, 8'h77);
        chk(16'(shadow_active[111:104]), 16'h0000);
        wr1(13'h00ff, 8'h02);
        chk(16'(ap_n), 16'h0000);
        chk(16'(shadow_active[7:0]), 16'h0000);
        wr1(13'h00ff, 8'h01);
        chk(16'(ap_n), 16'h0001);
        chk(16'(shadow_active[7:0]), 16'h003c);
        chk(16'(shadow_active[111:104]), 16'h0077);
        rd1(13'h00ff);
        chk(16'(rx[0]), 16'h0000);
        wr1(13'h0000, 8'h40);
        chk(16'(lsb_first), 16'h0001);
        host.lsb = 1'b1;
        wr1(13'h0030, 8'h83);
        chk(16'(last_a), 16'h0030);
        chk(16'(last_d), 16'h0083);
        rd1(13'h0000);
        chk(16'(rx[0]), 16'h0040);
        chk(16'(pins_secondary), 16'h0001);
        final_report;
    end
endmodule // testbench
